// [design/sld_top.sv]
`include "sld_regs.svh"
module sld_top #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output sld_pkg::sld_resp_type bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output sld_pkg::sld_resp_type rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq,
  // Serializer pins
  input wire logic transmit_clock,
  input wire logic tx_edge_select,
  input wire logic serial_output_enable,
  input wire logic tx_power_down_n,
  input wire logic tx_sync_a,
  input wire logic tx_sync_b,
  input wire logic [DATA_W-1:0] tx_data_in,
  output logic serial_out_pos,
  output logic serial_out_neg,
  output logic serial_out_oe,
  // Deserializer pins
  input wire logic serial_in_pos,
  input wire logic serial_in_neg,
  input wire logic rx_power_down_n,
  input wire logic rx_output_enable,
  input wire logic rx_edge_select,
  input wire logic pll_reference_clock,
  output logic [DATA_W-1:0] parallel_data_out,
  output logic parallel_data_oe,
  output logic recovered_clock,
  output logic recovered_clock_oe,
  output logic lock_n,
  output logic lock_oe,
  // Test access inputs with drive indication
  input wire logic jtag_tdi,
  input wire logic jtag_tdi_driven,
  input wire logic jtag_tms,
  input wire logic jtag_tms_driven,
  input wire logic jtag_trst,
  input wire logic jtag_trst_driven
);
  import sld_pkg::*;

  // ***************************************************
  // Elaboration checks
  // ***************************************************
  // Sync word and frame layout are fixed for ten data bits
  if (DATA_W != 10) begin : g_bad_width
    $error("sld_top: DATA_W must be 10");
  end
  if (ADDR_W < 4) begin : g_bad_addr
    $error("sld_top: ADDR_W must be at least 4");
  end

  // ***************************************************
  // Pin synchronisers
  // ***************************************************
  localparam int NPIN = DATA_W + 18;
  wire [NPIN-1:0] pins_in = {tx_data_in, transmit_clock, tx_edge_select,
    serial_output_enable, tx_power_down_n, tx_sync_a, tx_sync_b,
    serial_in_pos, serial_in_neg, rx_power_down_n, rx_output_enable,
    rx_edge_select, pll_reference_clock, jtag_tdi, jtag_tdi_driven,
    jtag_tms, jtag_tms_driven, jtag_trst, jtag_trst_driven};
  logic [NPIN-1:0] meta_r; // First stage, read only by second stage
  logic [NPIN-1:0] pin_r; // Second stage, safe to use

  // Two flops per pin; every pin is asynchronous to aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      pin_r <= '0;
    end else begin
      meta_r <= pins_in;
      pin_r <= meta_r;
    end
  end

  // Named views of synchronised pins
  wire [DATA_W-1:0] s_din = pin_r[NPIN-1:18];
  wire s_tx_clk = pin_r[17];
  wire s_tx_edge = pin_r[16];
  wire s_tx_oe = pin_r[15];
  wire s_tx_pwr = pin_r[14];
  wire s_sync_a = pin_r[13];
  wire s_sync_b = pin_r[12];
  wire s_rin_pos = pin_r[11];
  wire s_rin_neg = pin_r[10];
  wire s_rx_pwr = pin_r[9];
  wire s_ren = pin_r[8];
  wire s_rx_edge = pin_r[7];
  wire s_ref = pin_r[6];
  // Undriven test inputs read as high
  wire tdi_lvl = pin_r[4] ? pin_r[5] : 1'b1;
  wire tms_lvl = pin_r[2] ? pin_r[3] : 1'b1;
  wire trst_lvl = pin_r[0] ? pin_r[1] : 1'b1;

  // ***************************************************
  // Reference clock presence
  // ***************************************************
  logic ref_d_r; // Previous reference level
  logic ref_seen_r; // Reference has toggled since power-up

  // Receiver stays asleep until a reference edge is seen
  always_ff @(posedge aclk) begin
    if (!aresetn || !s_rx_pwr) begin
      ref_d_r <= 1'b0;
      ref_seen_r <= 1'b0;
    end else begin
      ref_d_r <= s_ref;
      ref_seen_r <= ref_seen_r | (s_ref ^ ref_d_r);
    end
  end

  // ***************************************************
  // Registers
  // ***************************************************
  logic ctrl_loop_r; // Loop serial output back into receiver
  logic [`SLD_IRQ_W-1:0] irq_stat_r; // Sticky event bits
  logic [`SLD_IRQ_W-1:0] irq_mask_r; // Interrupt enables
  logic awready_r;
  logic arready_r;

  wire ser_sync_active;
  wire ser_sync_done;
  wire des_locked;
  wire des_gain;
  wire des_loss;
  wire ser_pos;

  // Write and read decode
  wire wr_take = awready_r & awvalid & wvalid;
  wire rd_take = arready_r & arvalid;
  wire wr_ctrl = wr_take & (awaddr == ADDR_W'(`SLD_OFF_CTRL)) & wstrb[0];
  wire wr_clr = wr_take & (awaddr == ADDR_W'(`SLD_OFF_IRQ_STAT)) & wstrb[0];
  wire wr_mask = wr_take & (awaddr == ADDR_W'(`SLD_OFF_IRQ_MASK)) & wstrb[0];
  wire wr_hit = (awaddr == ADDR_W'(`SLD_OFF_CTRL)) |
    (awaddr == ADDR_W'(`SLD_OFF_STATUS)) |
    (awaddr == ADDR_W'(`SLD_OFF_IRQ_STAT)) |
    (awaddr == ADDR_W'(`SLD_OFF_IRQ_MASK));
  wire rd_ctrl = (araddr == ADDR_W'(`SLD_OFF_CTRL));
  wire rd_status = (araddr == ADDR_W'(`SLD_OFF_STATUS));
  wire rd_stat = (araddr == ADDR_W'(`SLD_OFF_IRQ_STAT));
  wire rd_mask = (araddr == ADDR_W'(`SLD_OFF_IRQ_MASK));
  wire rd_hit = rd_ctrl | rd_status | rd_stat | rd_mask;
  wire [`SLD_ST_W-1:0] status_w = {trst_lvl, tms_lvl, tdi_lvl, ref_seen_r,
    s_rx_pwr, s_tx_pwr, ser_sync_active, des_locked};
  wire [31:0] rd_mux = rd_ctrl ? {31'h0, ctrl_loop_r} :
    rd_status ? {24'h0, status_w} :
    rd_stat ? {29'h0, irq_stat_r} :
    rd_mask ? {29'h0, irq_mask_r} : 32'h0;
  wire [`SLD_IRQ_W-1:0] events = {ser_sync_done, des_loss, des_gain};
  // A new event wins over a clear in the same cycle
  wire [`SLD_IRQ_W-1:0] stat_nxt =
    (irq_stat_r & ~(wr_clr ? wdata[`SLD_IRQ_W-1:0] : '0)) | events;

  // Write channel: take address and data together, then respond
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `SLD_RESP_OKAY;
    end else begin
      awready_r <= awvalid & wvalid & ~awready_r & ~bvalid;
      if (wr_take) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? `SLD_RESP_OKAY : `SLD_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  assign awready = awready_r;
  assign wready = awready_r;

  // Read channel: one-cycle ready, data registered at the take
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `SLD_RESP_OKAY;
    end else begin
      arready_r <= arvalid & ~arready_r & ~rvalid;
      if (rd_take) begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_hit ? `SLD_RESP_OKAY : `SLD_RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
  assign arready = arready_r;

  // Control, sticky status, mask and interrupt line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_loop_r <= 1'b0;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_loop_r <= wdata[`SLD_CTRL_LOOPBACK];
      end
      if (wr_mask) begin
        irq_mask_r <= wdata[`SLD_IRQ_W-1:0];
      end
      irq_stat_r <= stat_nxt;
      irq <= |(stat_nxt & irq_mask_r);
    end
  end

  // ***************************************************
  // Serializer and deserializer
  // ***************************************************
  sld_ser #(
    .DATA_W(DATA_W),
    .SYNC_SYMS(`SLD_SYNC_SYMS)
  ) u_ser (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(s_tx_pwr),
    .tx_clk_s(s_tx_clk),
    .edge_sel(s_tx_edge),
    .sync_req(s_sync_a | s_sync_b),
    .oe_req(s_tx_oe),
    .din(s_din),
    .serial_out_pos(ser_pos),
    .serial_out_neg(serial_out_neg),
    .serial_out_oe(serial_out_oe),
    .sync_active(ser_sync_active),
    .sync_done(ser_sync_done)
  );
  assign serial_out_pos = ser_pos;

  // Differential receive bit, or the local output when looped back
  wire rx_bit = ctrl_loop_r ? ser_pos : (s_rin_pos & ~s_rin_neg);

  sld_des #(
    .DATA_W(DATA_W),
    .LOCK_WORDS(`SLD_LOCK_WORDS),
    .LOSS_WORDS(`SLD_LOSS_WORDS)
  ) u_des (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(s_rx_pwr & ref_seen_r),
    .serial_bit(rx_bit),
    .edge_sel(s_rx_edge),
    .out_en(s_ren),
    .parallel_data_out(parallel_data_out),
    .parallel_data_oe(parallel_data_oe),
    .recovered_clock(recovered_clock),
    .recovered_clock_oe(recovered_clock_oe),
    .lock_n(lock_n),
    .lock_oe(lock_oe),
    .locked(des_locked),
    .lock_gain(des_gain),
    .lock_loss(des_loss)
  );
endmodule : sld_top

// [design/sld_regs.svh]
`ifndef SLD_REGS_SVH
`define SLD_REGS_SVH
// Functional notes
// - Capture all ten data inputs into holding register
// - Edge select high samples rising, low falling
// - Serial output enable low tri-states both lines
// - Power-down low stops PLL, tri-states, sleeps
// - Sync request sends at least 1024 sync symbols
// - Sync continues while request stays high
// - Two sync request inputs are ORed together
// - Undriven TDI, TMS, TRST default to high
// - Receive edge select picks data launch edge
// - Lock output low when locked, push-pull
// - Recovered clock at word rate times outputs
// - Output enable low tri-states data and clock
// - Two clock bits framed around each word
// - Lock lost after four consecutive bad words
// - Outputs tri-stated after power-up until locked

// ***************************************************
// Register byte offsets
// ***************************************************
`define SLD_OFF_CTRL 4'h0
`define SLD_OFF_STATUS 4'h4
`define SLD_OFF_IRQ_STAT 4'h8
`define SLD_OFF_IRQ_MASK 4'hC

// ***************************************************
// Field positions
// ***************************************************
`define SLD_CTRL_LOOPBACK 0
`define SLD_ST_LOCKED 0
`define SLD_ST_SYNC 1
`define SLD_ST_TX_PWR 2
`define SLD_ST_RX_PWR 3
`define SLD_ST_REF 4
`define SLD_ST_TDI 5
`define SLD_ST_TMS 6
`define SLD_ST_TRST 7
`define SLD_ST_W 8
`define SLD_IRQ_LOCK 0
`define SLD_IRQ_LOSS 1
`define SLD_IRQ_SYNC 2
`define SLD_IRQ_W 3

// ***************************************************
// Link constants
// ***************************************************
`define SLD_SYNC_SYMS 1024
`define SLD_LOSS_WORDS 4
`define SLD_LOCK_WORDS 4
`define SLD_SYNC_WORD 10'h3E0
`define SLD_FRAME_CLK_BITS 2
`define SLD_RESP_OKAY 2'h0
`define SLD_RESP_SLVERR 2'h2

`endif

// [design/sld_pkg.sv]
package sld_pkg;
  // AXI response code
  typedef logic [1:0] sld_resp_type;
  // Serializer word source
  typedef enum logic [0:0] {SER_DATA, SER_SYNC} sld_ser_state_type;
  // Deserializer lock state
  typedef enum logic [0:0] {DES_HUNT, DES_LOCKED} sld_des_state_type;
endpackage : sld_pkg

// [design/sld_ser.sv]
`include "sld_regs.svh"
module sld_ser #(
  parameter int DATA_W = 10,
  parameter int SYNC_SYMS = `SLD_SYNC_SYMS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic tx_clk_s,
  input wire logic edge_sel,
  input wire logic sync_req,
  input wire logic oe_req,
  input wire logic [DATA_W-1:0] din,
  output logic serial_out_pos,
  output logic serial_out_neg,
  output logic serial_out_oe,
  output logic sync_active,
  output logic sync_done
);
  import sld_pkg::*;
  localparam int FRAME = DATA_W + `SLD_FRAME_CLK_BITS;
  localparam int CW = $clog2(FRAME);
  localparam int SW = $clog2(SYNC_SYMS + 1);

  logic tx_clk_d_r; // Previous transmit clock level
  logic [DATA_W-1:0] hold_r; // Captured parallel word
  logic [FRAME-1:0] shift_r; // Frame being sent, MSB first
  logic [CW-1:0] bit_r; // Bit position in frame
  logic [SW-1:0] cnt_r; // Sync symbols sent in this burst
  logic pend_r; // Sync request seen since last frame load
  sld_ser_state_type state_r;

  // Active edge picked by edge select
  wire cap = edge_sel ? (tx_clk_s & ~tx_clk_d_r) : (~tx_clk_s & tx_clk_d_r);
  wire load = (bit_r == '0);
  // Short requests are remembered so a pulse between loads is not lost
  wire req = sync_req | pend_r;
  wire burst_short = (cnt_r != SW'(SYNC_SYMS));
  wire send_sync = (state_r == SER_SYNC) ? (burst_short | req) : req;
  wire [DATA_W-1:0] word = send_sync ? `SLD_SYNC_WORD : hold_r;
  wire [CW-1:0] bit_nxt = (bit_r == CW'(FRAME - 1)) ? '0 : bit_r + 1'b1;
  wire [SW-1:0] cnt_nxt = (state_r == SER_DATA) ? SW'(1) :
    (burst_short ? cnt_r + 1'b1 : cnt_r);

  // ***************************************************
  // Capture, framing and sync bursts
  // ***************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      tx_clk_d_r <= 1'b0;
      hold_r <= '0;
      shift_r <= '0;
      bit_r <= '0;
      cnt_r <= '0;
      pend_r <= 1'b0;
      state_r <= SER_DATA;
      serial_out_pos <= 1'b0;
      serial_out_neg <= 1'b0;
      serial_out_oe <= 1'b0;
      sync_active <= 1'b0;
      sync_done <= 1'b0;
    end else begin
      tx_clk_d_r <= tx_clk_s;
      // All ten bits move together on the active edge
      if (cap) begin
        hold_r <= din;
      end
      bit_r <= bit_nxt;
      sync_done <= 1'b0;
      if (load) begin
        // Leading one and trailing zero carry the timing
        shift_r <= {1'b1, word, 1'b0};
        pend_r <= 1'b0;
        sync_active <= send_sync;
        if (send_sync) begin
          state_r <= SER_SYNC;
          cnt_r <= cnt_nxt;
        end else begin
          state_r <= SER_DATA;
          cnt_r <= '0;
          sync_done <= (state_r == SER_SYNC);
        end
      end else begin
        shift_r <= {shift_r[FRAME-2:0], 1'b0};
        pend_r <= pend_r | sync_req;
      end
      serial_out_pos <= shift_r[FRAME-1];
      serial_out_neg <= ~shift_r[FRAME-1];
      serial_out_oe <= oe_req;
    end
  end
endmodule : sld_ser

// [design/sld_des.sv]
`include "sld_regs.svh"
module sld_des #(
  parameter int DATA_W = 10,
  parameter int LOCK_WORDS = `SLD_LOCK_WORDS,
  parameter int LOSS_WORDS = `SLD_LOSS_WORDS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic serial_bit,
  input wire logic edge_sel,
  input wire logic out_en,
  output logic [DATA_W-1:0] parallel_data_out,
  output logic parallel_data_oe,
  output logic recovered_clock,
  output logic recovered_clock_oe,
  output logic lock_n,
  output logic lock_oe,
  output logic locked,
  output logic lock_gain,
  output logic lock_loss
);
  import sld_pkg::*;
  localparam int FRAME = DATA_W + `SLD_FRAME_CLK_BITS;
  localparam int CW = $clog2(FRAME);
  localparam int HALF = FRAME / 2;
  localparam int GW = $clog2(LOCK_WORDS + 1);
  localparam int BW = $clog2(LOSS_WORDS + 1);

  logic [FRAME-1:0] win_r; // Last frame's worth of serial bits
  logic [CW-1:0] bit_r; // Assumed bit position
  logic [GW-1:0] good_r; // Consecutive good frames while hunting
  logic [BW-1:0] bad_r; // Consecutive bad frames while locked
  logic [DATA_W-1:0] word_r; // Last good word
  sld_des_state_type state_r;

  wire boundary = (bit_r == CW'(FRAME - 1));
  wire frame_ok = win_r[FRAME-1] & ~win_r[0];
  // A failed frame while hunting holds the counter: slip one bit
  wire slip = boundary & ~frame_ok & (state_r == DES_HUNT);
  wire [CW-1:0] bit_nxt = boundary ? (slip ? bit_r : '0) : bit_r + 1'b1;
  wire launch = edge_sel ? (bit_r == '0) : (bit_r == CW'(HALF));

  // ***************************************************
  // Alignment, lock tracking and output timing
  // ***************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      win_r <= '0;
      bit_r <= '0;
      good_r <= '0;
      bad_r <= '0;
      word_r <= '0;
      state_r <= DES_HUNT;
      parallel_data_out <= '0;
      parallel_data_oe <= 1'b0;
      recovered_clock <= 1'b0;
      recovered_clock_oe <= 1'b0;
      lock_n <= 1'b1;
      lock_oe <= 1'b0;
      locked <= 1'b0;
      lock_gain <= 1'b0;
      lock_loss <= 1'b0;
    end else begin
      win_r <= {win_r[FRAME-2:0], serial_bit};
      bit_r <= bit_nxt;
      lock_gain <= 1'b0;
      lock_loss <= 1'b0;
      if (boundary) begin
        unique case (state_r)
          DES_HUNT: begin
            if (!frame_ok) begin
              good_r <= '0;
            end else if (good_r == GW'(LOCK_WORDS - 1)) begin
              state_r <= DES_LOCKED;
              good_r <= '0;
              bad_r <= '0;
              word_r <= win_r[FRAME-2:1];
              lock_gain <= 1'b1;
            end else begin
              good_r <= good_r + 1'b1;
            end
          end
          DES_LOCKED: begin
            if (frame_ok) begin
              bad_r <= '0;
              word_r <= win_r[FRAME-2:1];
            end else if (bad_r == BW'(LOSS_WORDS - 1)) begin
              // Only a full run of bad words drops lock
              state_r <= DES_HUNT;
              bad_r <= '0;
              lock_loss <= 1'b1;
            end else begin
              bad_r <= bad_r + 1'b1;
            end
          end
        endcase
      end
      locked <= (state_r == DES_LOCKED);
      // High for the first half of each frame: word-rate clock
      recovered_clock <= (bit_r < CW'(HALF));
      if (launch) begin
        parallel_data_out <= word_r;
      end
      // Data and clock float unless enabled and locked
      parallel_data_oe <= out_en & (state_r == DES_LOCKED);
      recovered_clock_oe <= out_en & (state_r == DES_LOCKED);
      lock_n <= (state_r != DES_LOCKED);
      lock_oe <= 1'b1;
    end
  end
endmodule : sld_des

// [dv/sld_top_asserts.sv]
// ********
// Pin behaviour checker
// ********
module sld_top_asserts #(
  parameter int DATA_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic serial_output_enable,
  input wire logic tx_power_down_n,
  input wire logic rx_power_down_n,
  input wire logic rx_output_enable,
  input wire logic serial_out_pos,
  input wire logic serial_out_neg,
  input wire logic serial_out_oe,
  input wire logic [DATA_W-1:0] parallel_data_out,
  input wire logic parallel_data_oe,
  input wire logic recovered_clock,
  input wire logic recovered_clock_oe,
  input wire logic lock_n,
  input wire logic lock_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // One domain, so clock and reset are given once
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Four cycles cover the two sync flops and the output flop
  property p_txoe_off;
    (!serial_output_enable) [*4] |-> !serial_out_oe;
  endproperty
  a_txoe_off: assert property (p_txoe_off) else $error("tx driven off");
  property p_diff;
    serial_out_oe |-> (serial_out_neg == !serial_out_pos);
  endproperty
  a_diff: assert property (p_diff) else $error("tx pair not inverse");
  property p_tx_sleep;
    (!tx_power_down_n) [*4] |-> !serial_out_oe;
  endproperty
  a_tx_sleep: assert property (p_tx_sleep) else $error("tx awake in sleep");
  property p_rx_sleep;
    (!rx_power_down_n) [*4] |-> !(lock_oe || parallel_data_oe);
  endproperty
  a_rx_sleep: assert property (p_rx_sleep) else $error("rx awake in sleep");
  property p_rx_off;
    (!rx_output_enable) [*4] |-> !(parallel_data_oe || recovered_clock_oe);
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx driven while off");
  // One cycle of slack where lock and enables change together
  property p_unlocked;
    lock_n && $past(lock_n) |-> !(parallel_data_oe || recovered_clock_oe);
  endproperty
  a_unlocked: assert property (p_unlocked) else $error("rx driven unlocked");
  property p_lock_drive;
    !lock_n |-> lock_oe;
  endproperty
  a_lock_drive: assert property (p_lock_drive) else $error("lock not driven");
  // Word clock is high for six bit times, then low
  property p_rclk;
    $rose(recovered_clock) && !lock_n |=> recovered_clock [*5] ##1 !recovered_clock;
  endproperty
  a_rclk: assert property (p_rclk) else $error("word clock shape");
  property p_data_edge;
    parallel_data_oe && $changed(parallel_data_out) |-> $changed(recovered_clock);
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("data off edge");
endmodule : sld_top_asserts

bind sld_top sld_top_asserts #(.DATA_W(DATA_W)) u_asserts (
  .aclk(aclk), .aresetn(aresetn), .serial_output_enable(serial_output_enable),
  .tx_power_down_n(tx_power_down_n), .rx_power_down_n(rx_power_down_n),
  .rx_output_enable(rx_output_enable), .serial_out_pos(serial_out_pos),
  .serial_out_neg(serial_out_neg), .serial_out_oe(serial_out_oe),
  .parallel_data_out(parallel_data_out), .parallel_data_oe(parallel_data_oe),
  .recovered_clock(recovered_clock), .recovered_clock_oe(recovered_clock_oe),
  .lock_n(lock_n), .lock_oe(lock_oe));

// [dv/sld_peer.sv]
// ********
// Far side: host clocks and peer serial line
// ********
module sld_peer (
  input wire logic aclk,
  input wire logic serial_out_pos,
  input wire logic serial_out_neg,
  input wire logic serial_out_oe,
  output logic serial_in_pos,
  output logic serial_in_neg,
  output logic transmit_clock,
  output logic pll_reference_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] div_r; // Word clock divider
  // Released line: failsafe bias pulls pos high and neg low
  assign serial_in_pos = serial_out_oe ? serial_out_pos : 1'b1;
  assign serial_in_neg = serial_out_oe ? serial_out_neg : 1'b0;
  initial {div_r, transmit_clock, pll_reference_clock} = 8'h00;
  // Word clock scaled down so the pin sampler can follow it
  always @(posedge aclk) begin
    pll_reference_clock <= ~pll_reference_clock;
    div_r <= (div_r == 6'h27) ? 6'h00 : div_r + 6'h01;
    if (div_r == 6'h27) begin
      transmit_clock <= ~transmit_clock;
    end
  end
endmodule : sld_peer

// [dv/serdes_link_pin_control_bench.sv]
module serdes_link_pin_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import sld_pkg::*;
  // ********
  // Signals
  // ********
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  sld_resp_type bresp, rresp, rs;
  logic transmit_clock, tx_edge_select, serial_output_enable, tx_power_down_n;
  logic tx_sync_a, tx_sync_b, serial_in_pos, serial_in_neg, rx_power_down_n;
  logic rx_output_enable, rx_edge_select, pll_reference_clock;
  logic [9:0] tx_data_in, parallel_data_out;
  logic serial_out_pos, serial_out_neg, serial_out_oe, parallel_data_oe;
  logic recovered_clock, recovered_clock_oe, lock_n, lock_oe;
  logic [2:0] jv, jd; // Test pin values and driven flags
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0;
  // Register rows: address, test pins, compare mask, expected value
  typedef struct {
    logic [3:0] a; logic [2:0] v; logic [2:0] d; logic [31:0] m; logic [31:0] e;
  } sld_row_type;
  sld_row_type rows [6] = '{'{4'h0, 3'h0, 3'h0, 32'hFFFFFFFF, 32'h0},
    '{4'h8, 3'h0, 3'h0, 32'hFFFFFFFF, 32'h0}, '{4'hC, 3'h0, 3'h0, 32'hFFFFFFFF, 32'h0},
    '{4'h4, 3'h0, 3'h0, 32'hE0, 32'hE0}, '{4'h4, 3'h0, 3'h7, 32'hE0, 32'h0},
    '{4'h4, 3'h5, 3'h7, 32'hE0, 32'hA0}};
  sld_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq),
    .transmit_clock(transmit_clock), .tx_edge_select(tx_edge_select),
    .serial_output_enable(serial_output_enable), .tx_power_down_n(tx_power_down_n),
    .tx_sync_a(tx_sync_a), .tx_sync_b(tx_sync_b), .tx_data_in(tx_data_in),
    .serial_out_pos(serial_out_pos), .serial_out_neg(serial_out_neg),
    .serial_out_oe(serial_out_oe), .serial_in_pos(serial_in_pos),
    .serial_in_neg(serial_in_neg), .rx_power_down_n(rx_power_down_n),
    .rx_output_enable(rx_output_enable), .rx_edge_select(rx_edge_select),
    .pll_reference_clock(pll_reference_clock),
    .parallel_data_out(parallel_data_out), .parallel_data_oe(parallel_data_oe),
    .recovered_clock(recovered_clock), .recovered_clock_oe(recovered_clock_oe),
    .lock_n(lock_n), .lock_oe(lock_oe), .jtag_tdi(jv[0]), .jtag_tdi_driven(jd[0]),
    .jtag_tms(jv[1]), .jtag_tms_driven(jd[1]), .jtag_trst(jv[2]),
    .jtag_trst_driven(jd[2]));
  sld_peer u_peer (.aclk(aclk), .serial_out_pos(serial_out_pos),
    .serial_out_neg(serial_out_neg), .serial_out_oe(serial_out_oe),
    .serial_in_pos(serial_in_pos), .serial_in_neg(serial_in_neg),
    .transmit_clock(transmit_clock), .pll_reference_clock(pll_reference_clock));
  // ********
  // Clock, timeout and helpers
  // ********
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Two sync bursts dominate the run; ceiling leaves ample margin
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      conclude();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t ns: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(posedge aclk);
  endtask : step
  // Address and data offered together, held until taken
  task wr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while ((awready & wready) !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr
  task rd_reg(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd_reg
  task conclude;
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  // ********
  // Main sequence
  // ********
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb, jv, jd, tx_sync_a, tx_sync_b} = 52'hF00;
    {tx_edge_select, serial_output_enable, tx_power_down_n} = 3'h7;
    {rx_power_down_n, rx_output_enable, rx_edge_select} = 3'h7;
    tx_data_in = 10'h2A5;
    step(6);
    aresetn <= 1'b1;
    // Reset values, test pins undriven and driven, unmapped read
    foreach (rows[i]) begin
      jv <= rows[i].v;
      jd <= rows[i].d;
      step(4);
      rd_reg(rows[i].a);
      chk(rd & rows[i].m, rows[i].e);
    end
    rd_reg(4'h2);
    chk({30'h0, rs}, 32'h2);
    $display("Test register table done");
    // Short request pulse starts a full burst and lock
    wr(4'hC, 32'h7);
    tx_sync_a <= 1'b1;
    step(4);
    tx_sync_a <= 1'b0;
    t0 = cyc;
    while (lock_n !== 1'b0) @(posedge aclk);
    step(2);
    chk({31'h0, irq}, 32'h1);
    do rd_reg(4'h8); while (rd[2] !== 1'b1);
    chk({31'h0, cyc - t0 >= 12288}, 32'h1);
    step(400);
    chk({22'h0, parallel_data_out}, 32'h2A5);
    tx_data_in <= 10'h15A;
    tx_edge_select <= 1'b0;
    rx_edge_select <= 1'b0;
    step(400);
    chk({22'h0, parallel_data_out}, 32'h15A);
    $display("Test sync and data done");
    // Mask hides pending events; a one clears them
    wr(4'hC, 32'h0);
    step(2);
    chk({31'h0, irq}, 32'h0);
    wr(4'h8, 32'h7);
    rd_reg(4'h8);
    chk(rd, 32'h0);
    wr(4'hC, 32'h7);
    // Held second request keeps the burst going
    tx_sync_b <= 1'b1;
    step(13000);
    rd_reg(4'h4);
    chk(rd & 32'h2, 32'h2);
    tx_sync_b <= 1'b0;
    step(100);
    rd_reg(4'h4);
    chk(rd & 32'h2, 32'h0);
    $display("Test held sync done");
    // Released line gives bad frames; lock drops only after four
    serial_output_enable <= 1'b0;
    step(30);
    chk({31'h0, lock_n}, 32'h0);
    step(70);
    chk({30'h0, lock_n, parallel_data_oe}, 32'h2);
    rd_reg(4'h8);
    chk(rd & 32'h2, 32'h2);
    tx_power_down_n <= 1'b0;
    rx_power_down_n <= 1'b0;
    rx_output_enable <= 1'b0;
    step(5);
    chk({30'h0, serial_out_oe, lock_oe}, 32'h0);
    wr(4'h2, 32'h1);
    chk({30'h0, rs}, 32'h2);
    wr(4'h0, 32'h1);
    rd_reg(4'h0);
    chk(rd, 32'h1);
    $display("Test loss and sleep done");
    conclude();
  end
endmodule : serdes_link_pin_control_bench
